/* rtl/port_pkg.sv */
// package: register map, mode codes and carrier structs for the port pin mode control block
// Summary of operation
// - mode bits: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain (low bit first)
// - each pin's mode is set by one bit in each of two per-port registers
// - tristate fuse enabled: every pin resets into input-only mode
// - fuse disabled: non-analog pins reset quasi-bidirectional with latch high
// - analog pins (port 0, port 2 bits 4-7) always reset input-only
// - power-down disables input buffers except interrupt, reset and oscillator pins
// - port 1 pins used as interrupt inputs keep inputs alive in power-down
// - quasi mode: very weak pull-up on whenever latch is one
// - quasi mode: weak pull-up on only while latch and pin are both one
// - quasi mode: latch rising zero to one fires strong pull-up for two clocks
// - quasi mode: latch zero drives pin low strongly
// - input-only mode: all pull-ups and the pull-down are off
// - open-drain mode: no pull-ups, pull-down only while latch is zero
// - push-pull mode: strong pull-up while latch one, pull-down while zero
// - port 2 bits 4-7 input off when a comparator is on and pin input-only
// - comparator on, open-drain with latch one: digital input stays enabled
// - converter on, not DAC: port 0 input-only pins lose digital input
// - DAC mode forces port 2 bits 2 and 3 into input-only
// - plain reads return pin levels, read-modify-write reads return the latch
// - bit writes read the whole latch, change one bit, write the byte back
package port_pkg;
  localparam int NUM_PORTS = 5;
  localparam int PORT_W = 8;
  localparam int PIN_COUNT = NUM_PORTS * PORT_W;

  // special function register addresses
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
  localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
  localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
  localparam logic [7:0] ADDR_PORT4_DATA = 8'hC0;
  localparam logic [7:0] ADDR_PORT0_MODE_SEL_LO = 8'hBA;
  localparam logic [7:0] ADDR_PORT0_MODE_SEL_HI = 8'hBB;
  localparam logic [7:0] ADDR_PORT1_MODE_SEL_LO = 8'hC2;
  localparam logic [7:0] ADDR_PORT1_MODE_SEL_HI = 8'hC3;
  localparam logic [7:0] ADDR_PORT2_MODE_SEL_LO = 8'hC4;
  localparam logic [7:0] ADDR_PORT2_MODE_SEL_HI = 8'hC5;
  localparam logic [7:0] ADDR_PORT3_MODE_SEL_LO = 8'hC6;
  localparam logic [7:0] ADDR_PORT3_MODE_SEL_HI = 8'hC7;
  localparam logic [7:0] ADDR_PORT4_MODE_SEL_LO = 8'hBE;
  localparam logic [7:0] ADDR_PORT4_MODE_SEL_HI = 8'hBF;

  // analog pin masks and fixed-purpose pin positions
  localparam logic [7:0] PORT0_ANALOG_MASK = 8'hFF;
  localparam logic [7:0] PORT2_ANALOG_MASK = 8'hF0;
  localparam logic [7:0] PORT2_DAC_MASK = 8'h0C;
  localparam logic [7:0] PORT3_WAKE_MASK = 8'h0C;
  localparam logic [7:0] PORT4_WAKE_MASK = 8'h07;

  // reset values of latches and mode bits
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] MODE_LO_TRISTATE = 8'hFF;
  localparam logic [7:0] MODE_HI_RESET = 8'h00;

  // strong pull-up length in clock cycles
  localparam logic [1:0] STRONG_PULLUP_CYCLES = 2'd2;

  typedef enum logic [1:0] {
    MODE_QUASI = 2'b00,
    MODE_PUSH_PULL = 2'b10,
    MODE_INPUT_ONLY = 2'b01,
    MODE_OPEN_DRAIN = 2'b11
  } pin_mode_e;

  // cpu special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // analog peripheral and power state seen by the ports
  typedef struct packed {
    logic comparator_a_enable;
    logic comparator_b_enable;
    logic converter_enable;
    logic dac_select;
    logic power_down;
    logic [7:0] gp_int_enable;
  } analog_ctl_s;

  // pin drive controls, one bit per pin
  typedef struct packed {
    logic [PIN_COUNT-1:0] very_weak_pu;
    logic [PIN_COUNT-1:0] weak_pu;
    logic [PIN_COUNT-1:0] strong_pu;
    logic [PIN_COUNT-1:0] pull_down;
    logic [PIN_COUNT-1:0] input_en;
  } pin_drive_s;
endpackage

/* rtl/port_pin_mode_control.sv */
// module: five 8-bit gpio ports with per-pin mode control and sfr access
`timescale 1ns/100ps
module port_pin_mode_control (
  input wire logic clock,                         // cpu clock, 250 MHz
  input wire logic rst_n,                         // async active-low reset
  input wire logic tristate_fuse,                 // fuse: all pins input-only after reset
  input wire port_pkg::sfr_req_s sfr_req,         // cpu register access
  output logic [7:0] sfr_rdata,                   // read data, registered
  output logic sfr_hit,                           // address belongs to this block
  input wire port_pkg::analog_ctl_s analog_ctl,   // comparator, converter and power state
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_in, // raw pin levels
  output port_pkg::pin_drive_s pin_drive,         // driver and input buffer controls
  output logic [port_pkg::PIN_COUNT-1:0] pin_out, // pin level while driven
  output logic [port_pkg::PIN_COUNT-1:0] pin_oe,  // high while a driver is on
  output logic [port_pkg::PIN_COUNT-1:0] pin_sensed // gated, synchronised pin levels
);
  import port_pkg::*;

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] latch;
    logic [NUM_PORTS-1:0][7:0] mode_lo;
    logic [NUM_PORTS-1:0][7:0] mode_hi;
    logic [NUM_PORTS-1:0][7:0] latch_prev;
    logic [PIN_COUNT-1:0][1:0] strong_cnt;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [7:0] rdata;
    logic fuse_taken;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [1:0] rst_sync;
  logic rst_n_int;
  logic [NUM_PORTS-1:0][7:0] eff_lo;
  logic [NUM_PORTS-1:0][7:0] eff_hi;
  pin_drive_s drive;

  // decode a mode pair into a mode code
  function automatic pin_mode_e pin_mode(input logic lo, input logic hi);
    pin_mode_e m;
    m = pin_mode_e'({hi, lo});
    return m;
  endfunction

  // reset values of one port's mode bits, analog pins always tristate
  function automatic logic [7:0] reset_lo(input int p, input logic fuse);
    logic [7:0] v;
    v = fuse ? MODE_LO_TRISTATE : 8'h00;
    if (p == 0) begin
      v = v | PORT0_ANALOG_MASK;
    end
    if (p == 2) begin
      v = v | PORT2_ANALOG_MASK;
    end
    return v;
  endfunction

  // index of a port data register, or -1
  function automatic int data_index(input logic [7:0] a);
    int i;
    i = -1;
    case (a)
      ADDR_PORT0_DATA: i = 0;
      ADDR_PORT1_DATA: i = 1;
      ADDR_PORT2_DATA: i = 2;
      ADDR_PORT3_DATA: i = 3;
      ADDR_PORT4_DATA: i = 4;
      default: i = -1;
    endcase
    return i;
  endfunction

  // port index of a mode register; bit 3 of the result flags the high register
  function automatic int mode_index(input logic [7:0] a);
    int i;
    i = -1;
    case (a)
      ADDR_PORT0_MODE_SEL_LO: i = 0;
      ADDR_PORT1_MODE_SEL_LO: i = 1;
      ADDR_PORT2_MODE_SEL_LO: i = 2;
      ADDR_PORT3_MODE_SEL_LO: i = 3;
      ADDR_PORT4_MODE_SEL_LO: i = 4;
      ADDR_PORT0_MODE_SEL_HI: i = 8;
      ADDR_PORT1_MODE_SEL_HI: i = 9;
      ADDR_PORT2_MODE_SEL_HI: i = 10;
      ADDR_PORT3_MODE_SEL_HI: i = 11;
      ADDR_PORT4_MODE_SEL_HI: i = 12;
      default: i = -1;
    endcase
    return i;
  endfunction

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync[1];

  // dac mode overrides port 2 bits 2 and 3 to input-only
  always_comb begin
    eff_lo = state_reg.mode_lo;
    eff_hi = state_reg.mode_hi;
    if (analog_ctl.converter_enable && analog_ctl.dac_select) begin
      eff_lo[2] = eff_lo[2] | PORT2_DAC_MASK;
      eff_hi[2] = eff_hi[2] & ~PORT2_DAC_MASK;
    end
  end

  // per-pin driver and input buffer control
  always_comb begin
    int p;
    int b;
    int n;
    logic lat;
    logic comp_on;
    logic adc_on;
    pin_mode_e m;
    p = 0;
    b = 0;
    n = 0;
    lat = 1'b0;
    m = MODE_QUASI;
    comp_on = analog_ctl.comparator_a_enable | analog_ctl.comparator_b_enable;
    adc_on = analog_ctl.converter_enable & ~analog_ctl.dac_select;
    drive = '0;
    for (p = 0; p < NUM_PORTS; p++) begin
      for (b = 0; b < PORT_W; b++) begin
        n = p * PORT_W + b;
        lat = state_reg.latch[p][b];
        m = pin_mode(eff_lo[p][b], eff_hi[p][b]);
        drive.input_en[n] = 1'b1;
        case (m)
          MODE_QUASI: begin
            drive.very_weak_pu[n] = lat;
            drive.weak_pu[n] = lat & state_reg.sync2[n];
            // the rise itself gives the first cycle, the timer gives the rest
            drive.strong_pu[n] = lat && (!state_reg.latch_prev[p][b]
              || (state_reg.strong_cnt[n] != 2'd0));
            drive.pull_down[n] = ~lat;
          end
          MODE_PUSH_PULL: begin
            drive.strong_pu[n] = lat;
            drive.pull_down[n] = ~lat;
          end
          MODE_OPEN_DRAIN: begin
            drive.pull_down[n] = ~lat;
          end
          default: begin
            // input-only: every driver stays off
          end
        endcase
        // analog pins: input-only disables the buffer, open-drain keeps it
        if (p == 2 && PORT2_ANALOG_MASK[b] && comp_on && m == MODE_INPUT_ONLY) begin
          drive.input_en[n] = 1'b0;
        end
        if (p == 0 && adc_on && m == MODE_INPUT_ONLY) begin
          drive.input_en[n] = 1'b0;
        end
        // power-down keeps only wake-capable inputs alive
        if (analog_ctl.power_down) begin
          if (!((p == 3 && PORT3_WAKE_MASK[b]) || (p == 4 && PORT4_WAKE_MASK[b])
                || (p == 1 && analog_ctl.gp_int_enable[b]))) begin
            drive.input_en[n] = 1'b0;
          end
        end
      end
    end
  end

  // next-state: register writes, strong pull-up timers, pin sampling, read data
  always_comb begin
    int di;
    int mi;
    int p;
    int n;
    logic [NUM_PORTS-1:0][7:0] pins_gated;
    state_next = state_reg;
    di = data_index(sfr_req.addr);
    mi = mode_index(sfr_req.addr);
    n = 0;
    pins_gated = '0;
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;
    for (p = 0; p < NUM_PORTS; p++) begin
      pins_gated[p] = state_reg.sync2[p*PORT_W +: PORT_W] & drive.input_en[p*PORT_W +: PORT_W];
    end
    // writes land on this edge and touch only the addressed register
    if (sfr_req.wr && di >= 0) begin
      state_next.latch[di] = sfr_req.wdata;
    end
    if (sfr_req.wr && mi >= 0) begin
      if (mi >= 8) begin
        state_next.mode_hi[mi-8] = sfr_req.wdata;
      end else begin
        state_next.mode_lo[mi] = sfr_req.wdata;
      end
    end
    // plain reads see the pins, read-modify-write reads see the latch
    if (sfr_req.rd) begin
      if (di >= 0) begin
        state_next.rdata = sfr_req.rmw ? state_reg.latch[di] : pins_gated[di];
      end else if (mi >= 8) begin
        state_next.rdata = state_reg.mode_hi[mi-8];
      end else if (mi >= 0) begin
        state_next.rdata = state_reg.mode_lo[mi];
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    // a rising latch bit arms a two-cycle strong pull-up
    state_next.latch_prev = state_reg.latch;
    for (n = 0; n < PIN_COUNT; n++) begin
      if (state_reg.latch[n/PORT_W][n%PORT_W] && !state_reg.latch_prev[n/PORT_W][n%PORT_W]) begin
        state_next.strong_cnt[n] = STRONG_PULLUP_CYCLES - 2'd1;
      end else if (state_reg.strong_cnt[n] != 2'd0) begin
        state_next.strong_cnt[n] = state_reg.strong_cnt[n] - 2'd1;
      end
    end
    // fuse is caught once after reset release, since an async reset may load only constants
    if (!state_reg.fuse_taken) begin
      state_next.fuse_taken = 1'b1;
      for (p = 0; p < NUM_PORTS; p++) begin
        state_next.mode_lo[p] = reset_lo(p, tristate_fuse);
        state_next.mode_hi[p] = MODE_HI_RESET;
      end
    end
  end

  // strong pull-up first cycle comes from the edge itself, so count one below the length
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= '0;
      state_reg.latch <= {NUM_PORTS{LATCH_RESET}};
      state_reg.latch_prev <= {NUM_PORTS{LATCH_RESET}};
      state_reg.mode_lo <= {NUM_PORTS{MODE_LO_TRISTATE}}; // held tristate until fuse taken
      state_reg.mode_hi <= {NUM_PORTS{MODE_HI_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs; pin_out is high only when the strong pull-up is on, strong drive counts as oe
  always_comb begin
    pin_drive = drive;
    pin_oe = drive.pull_down | drive.strong_pu;
    pin_out = drive.strong_pu;
    pin_sensed = state_reg.sync2 & drive.input_en;
    sfr_rdata = state_reg.rdata;
    sfr_hit = (data_index(sfr_req.addr) >= 0) || (mode_index(sfr_req.addr) >= 0);
  end
endmodule // port_pin_mode_control

/* sim/port_pin_mode_control_props.sv */
// checker: driver, input gate and read relations of the port block
`timescale 1ns/100ps
module port_pin_mode_control_props import port_pkg::*; (
  input wire logic clock, // cpu clock
  input wire logic rst_n, // async reset
  input wire logic tristate_fuse, // reset mode fuse
  input wire port_pkg::sfr_req_s sfr_req, // register access
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic sfr_hit, // mapped address
  input wire port_pkg::analog_ctl_s analog_ctl, // analog and power
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_in, // raw pins
  input wire port_pkg::pin_drive_s pin_drive, // driver controls
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_out, // driven level
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_oe, // driver on
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_sensed // gated pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // only strong drivers show in oe, weak pull-ups stay off the enable
  property p_oe; pin_oe == (pin_drive.strong_pu | pin_drive.pull_down); endproperty
  a_oe: assert property (p_oe) else $error("oe not from drivers");
  property p_out; (pin_out & pin_oe) == pin_drive.strong_pu; endproperty
  a_out: assert property (p_out) else $error("driven level wrong");
  property p_fight; (pin_drive.strong_pu & pin_drive.pull_down) == '0; endproperty
  a_fight: assert property (p_fight) else $error("pull-up against pull-down");
  property p_sense; (pin_sensed & ~pin_drive.input_en) == '0; endproperty
  a_sense: assert property (p_sense) else $error("gated pin leaks");
  // pulse on a quasi pin: exactly two cycles high
  property p_sp; $rose(pin_drive.strong_pu[8]) && pin_drive.very_weak_pu[8]
    |=> pin_drive.strong_pu[8] ##1 !pin_drive.strong_pu[8]; endproperty
  a_sp: assert property (p_sp) else $error("strong pulse length");
  property p_wvw; (pin_drive.weak_pu & ~pin_drive.very_weak_pu) == '0; endproperty
  a_wvw: assert property (p_wvw) else $error("weak without latch");
  // weak pull-up follows the synchronised pin, two cycles behind
  property p_wpin; (pin_drive.weak_pu & ~$past(pin_in, 2)) == '0; endproperty
  a_wpin: assert property (p_wpin) else $error("weak on low pin");
  property p_dac; analog_ctl.converter_enable && analog_ctl.dac_select |->
    ((pin_drive.strong_pu | pin_drive.pull_down | pin_drive.weak_pu |
    pin_drive.very_weak_pu) & {16'h0000, PORT2_DAC_MASK, 16'h0000}) == '0; endproperty
  a_dac: assert property (p_dac) else $error("dac pins driven");
  property p_pd; analog_ctl.power_down |-> (pin_drive.input_en & ~{PORT4_WAKE_MASK,
    PORT3_WAKE_MASK, 8'h00, analog_ctl.gp_int_enable, 8'h00}) == '0; endproperty
  a_pd: assert property (p_pd) else $error("input alive in power-down");
  property p_unm; sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !sfr_req.rd |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_pulse: cover property ($rose(pin_drive.strong_pu[8]));
  c_pd: cover property (analog_ctl.power_down);
  c_rmw: cover property (sfr_req.rd && sfr_req.rmw);
endmodule // port_pin_mode_control_props
bind port_pin_mode_control port_pin_mode_control_props u_props (.clock, .rst_n,
  .tristate_fuse, .sfr_req, .sfr_rdata, .sfr_hit, .analog_ctl, .pin_in, .pin_drive,
  .pin_out, .pin_oe, .pin_sensed);

/* sim/pin_world.sv */
// partner: outside circuit on the 40 port pins
`timescale 1ns/100ps
module pin_world import port_pkg::*; (
  input wire logic clock, // cpu clock
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_out, // device level
  input wire logic [port_pkg::PIN_COUNT-1:0] pin_oe, // device drives
  input wire logic [port_pkg::PIN_COUNT-1:0] pull_up, // weak pull-ups on
  input wire logic [port_pkg::PIN_COUNT-1:0] ext_en, // outside drives
  input wire logic [port_pkg::PIN_COUNT-1:0] ext_val, // outside level
  output logic [port_pkg::PIN_COUNT-1:0] level // resolved wire
);
  logic [PIN_COUNT-1:0] float_reg = 40'h55_5555_5555;
  // an open pin flips every cycle so no one reads it as a clean level
  always_ff @(posedge clock) float_reg <= ~float_reg;
  // strong drivers win, outside beats weak pull-ups
  assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pull_up | float_reg));
endmodule // pin_world

/* sim/port_pin_mode_control_tb.sv */
// testbench: port pin mode control regression
`timescale 1ns/100ps
module port_pin_mode_control_tb;
  import port_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tristate_fuse = 1'b0;
  sfr_req_s sfr_req = '0;
  analog_ctl_s analog_ctl = '0;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, pin_sensed, ext_en = '0, ext_val = '0;
  logic [7:0] sfr_rdata, rd_val, lat, r;
  logic sfr_hit;
  pin_drive_s pin_drive;
  int errors = 0, n_tests = 0, seed = 46460;
  logic [7:0] regs [15] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'hBA, 8'hBB, 8'hBE,
    8'hBF, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
  always #2 clock = ~clock;
  port_pin_mode_control DUT (.clock, .rst_n, .tristate_fuse, .sfr_req, .sfr_rdata,
    .sfr_hit, .analog_ctl, .pin_in, .pin_drive, .pin_out, .pin_oe, .pin_sensed);
  pin_world u_world (.clock, .pin_out, .pin_oe, .ext_en, .ext_val, .level(pin_in),
    .pull_up(pin_drive.weak_pu | pin_drive.very_weak_pu));
  // reset image: latches high, mode low bits set where input-only
  function automatic logic [7:0] exp_reg(logic [7:0] a, logic f);
    if (a[3:0] == 4'h0) return 8'hFF;
    if (a[0]) return 8'h00;
    if (f || a == 8'hBA) return 8'hFF;
    return (a == 8'hC4) ? 8'hF0 : 8'h00;
  endfunction
  // {strong, pull-down, very weak} after any pulse has ended; m is {hi, lo}
  function automatic logic [2:0] exp_drv(logic [1:0] m, logic l);
    case (m)
      2'd0: return {1'b0, ~l, l};
      2'd2: return {l, ~l, 1'b0};
      2'd3: return {1'b0, ~l, 1'b0};
      default: return 3'b000;
    endcase
  endfunction
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{1'b1, 1'b0, 1'b0, a, d};
    @(posedge clock);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic m);
    @(posedge clock);
    sfr_req <= '{1'b0, 1'b1, m, a, 8'h00};
    @(posedge clock);
    sfr_req.rd <= 1'b0;
    #1 rd_val = sfr_rdata;
  endtask
  // the fuse is held as a level through the release so its load edge sees it
  task automatic reset_check(logic f);
    @(posedge clock);
    rst_n <= 1'b0;
    tristate_fuse <= f;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    foreach (regs[i]) begin
      rd(regs[i], 1'b1);
      chk("reset reg", 40'(exp_reg(regs[i], f)), 40'(rd_val));
    end
    chk("reset pull-ups", f ? '0 : 40'hFF_FF0F_FF00, pin_drive.very_weak_pu);
  endtask
  task automatic test_done();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog far beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #(4 * 5000);
    errors++;
    test_done();
  end
  initial begin
    reset_check(1'b1);
    reset_check(1'b0);
    wr(ADDR_PORT1_DATA, 8'hFE);
    #1 chk("pull-down low latch", 40'd1, 40'(pin_drive.pull_down[8]));
    wr(ADDR_PORT1_DATA, 8'hFF);
    for (int c = 0; c < 3; c++) begin
      #1 chk("strong pulse", 40'(c < 2), 40'(pin_drive.strong_pu[8]));
      @(posedge clock);
    end
    for (int m = 0; m < 4; m++) begin
      lat = 8'($random(seed));
      wr(ADDR_PORT1_MODE_SEL_LO, {6'h00, m[0], 1'b0});
      wr(ADDR_PORT1_MODE_SEL_HI, {6'h00, m[1], 1'b0});
      wr(ADDR_PORT1_DATA, lat);
      repeat (3) @(posedge clock);
      #1 chk("pin mode", 40'(exp_drv(m[1:0], lat[1])), 40'({pin_drive.strong_pu[9],
        pin_drive.pull_down[9], (m == 2) ? 1'b0 : pin_drive.very_weak_pu[9]}));
    end
    wr(ADDR_PORT1_MODE_SEL_LO, 8'h00);
    wr(ADDR_PORT1_MODE_SEL_HI, 8'h00);
    lat = 8'($random(seed));
    r = 8'($random(seed));
    wr(ADDR_PORT1_DATA, lat);
    ext_en[15:8] <= r;
    repeat (4) @(posedge clock);
    rd(ADDR_PORT1_DATA, 1'b0);
    chk("pin read", 40'(lat & ~r), 40'(rd_val));
    chk("weak pull-up", 40'(lat & ~r), 40'(pin_drive.weak_pu[15:8]));
    rd(ADDR_PORT1_DATA, 1'b1);
    chk("latch read", 40'(lat), 40'(rd_val));
    wr(ADDR_PORT1_DATA, rd_val ^ 8'h01);
    rd(ADDR_PORT1_DATA, 1'b1);
    chk("bit write", 40'(lat ^ 8'h01), 40'(rd_val));
    rd(8'h81, 1'b0);
    chk("unmapped read", 40'h0, {rd_val, sfr_hit});
    // power-down keeps only wake pins and chosen interrupt pins
    r = 8'($random(seed));
    @(posedge clock);
    ext_en <= '0;
    analog_ctl <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, r};
    repeat (2) @(posedge clock);
    #1 chk("power-down inputs", {24'h070C00, r}, 40'(pin_drive.input_en[39:8]));
    @(posedge clock);
    analog_ctl <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
    repeat (2) @(posedge clock);
    #1 chk("analog inputs off", 40'h0,
      {pin_drive.input_en[23:20], pin_drive.input_en[7:0]});
    wr(ADDR_PORT2_MODE_SEL_HI, 8'h10);
    #1 chk("open-drain input", 40'd1, 40'(pin_drive.input_en[20]));
    @(posedge clock);
    analog_ctl.dac_select <= 1'b1;
    @(posedge clock);
    #1 chk("dac mode", 40'h3FC, {pin_drive.input_en[7:0],
      pin_drive.very_weak_pu[19:18]});
    test_done();
  end
endmodule // port_pin_mode_control_tb
